// ===== rtl/acsp_pkg.sv
package acsp_pkg;
	localparam int          WORD_BITS      = 16;
	localparam int          CLK_MHZ        = 40;
	localparam int          CONVERT_START_N_TIME_NS   = 10000;
	localparam int          CONVERT_START_N_CYCLES    = (CONVERT_START_N_TIME_NS * CLK_MHZ) / 1000;
	localparam int          EARLY_CYCLES   = 2;
	localparam int          SCLK_DIV       = 4;
	localparam logic [15:0] RESULT_INIT    = 16'h0000;
	localparam logic [15:0] RESULT_STEP    = 16'h0001;
	localparam int          IRQ_DONE_BIT   = 0;
	localparam int          IRQ_READ_BIT   = 1;
	localparam logic [1:0]  ADDR_STATUS    = 2'h0;
	localparam logic [1:0]  ADDR_MASK      = 2'h1;
	localparam logic [1:0]  ADDR_RESULT    = 2'h2;
	localparam logic [1:0]  ADDR_STATE     = 2'h3;

	typedef struct packed {
		logic convert_start_n;
		logic port_select_n;
		logic serial_clocking_select;
		logic shift_clock;
	} acsp_pins_t;

	// Synchroniser reset levels match idle pins, so no false shift-clock edge follows reset
	localparam acsp_pins_t PINS_IDLE = '{convert_start_n: 1'b1, port_select_n: 1'b1,
	                                     serial_clocking_select: 1'b0, shift_clock: 1'b0};
endpackage

// ===== rtl/acsp_top.sv
`timescale 1ns/1ps
module acsp_top (
	input  wire logic              clk_i,
	input  wire logic              reset_i,
	input  wire acsp_pkg::acsp_pins_t pins_i,
	input  wire logic [15:0]       sample_i,
	input  wire logic [1:0]        reg_addr_i,
	input  wire logic [15:0]       reg_wdata_i,
	input  wire logic              reg_write_i,
	input  wire logic              reg_read_i,
	output logic [15:0]            reg_rdata_o,
	output logic                   conversion_done_n_o,
	output logic                   serial_result_out_o,
	output logic                   serial_result_oe_o,
	output logic                   shift_clock_o,
	output logic                   shift_clock_oe_o,
	output logic                   irq_o
);
	typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_HOLD} acsp_state_t;

	acsp_pkg::acsp_pins_t meta_r;
	acsp_pkg::acsp_pins_t sync_r;
	logic                 sclk_prev_r;
	acsp_state_t          state_r;
	logic [15:0]          count_r;
	logic [15:0]          shift_r;
	logic [4:0]           bits_left_r;
	logic                 reading_r;
	logic [15:0]          result_r;
	logic                 done_n_r;
	logic [2:0]           div_r;
	logic                 sclk_r;
	logic [1:0]           status_r;
	logic [1:0]           mask_r;
	logic                 ext_rise;
	logic                 int_rise;
	logic                 adv;
	logic                 convert_start_n_end;
	logic                 self_mode;
	logic                 final_adv;

	// Register write decode, shared by the status and mask logic
	function automatic logic reg_hit(input logic       wr,
	                                 input logic [1:0] addr,
	                                 input logic [1:0] target);
		reg_hit = wr && (addr == target);
	endfunction

	// True when this advance moves the last bit of the word out
	function automatic logic last_bit(input logic       step,
	                                  input logic [4:0] left,
	                                  input logic       sel_n);
		last_bit = step && (left == 5'h01) && !sel_n;
	endfunction

	// Two flops on every pin; only the second stage is read
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			meta_r <= acsp_pkg::PINS_IDLE;
			sync_r <= acsp_pkg::PINS_IDLE;
			sclk_prev_r <= 1'b0;
		end else begin
			meta_r <= pins_i;
			sync_r <= meta_r;
			sclk_prev_r <= sync_r.shift_clock;
		end
	end

	assign self_mode = sync_r.serial_clocking_select;
	assign ext_rise  = sync_r.shift_clock & ~sclk_prev_r;
	assign int_rise  = (div_r == 3'(acsp_pkg::SCLK_DIV - 1)) & ~sclk_r;
	assign adv       = self_mode ? int_rise : ext_rise;
	assign convert_start_n_end  = (state_r == ST_CONVERT) && (count_r == 16'd0);
	assign final_adv = last_bit(adv, bits_left_r, sync_r.port_select_n);

	// Conversion sequencer
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_r  <= ST_IDLE;
			count_r  <= 16'd0;
			result_r <= acsp_pkg::RESULT_INIT;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (!sync_r.convert_start_n) begin
						state_r <= ST_CONVERT;
						count_r <= 16'(acsp_pkg::CONVERT_START_N_CYCLES - 1);
					end
				end
				ST_CONVERT: begin
					if (count_r == 16'd0) begin
						result_r <= sample_i;
						state_r  <= ST_HOLD;
					end else begin
						count_r <= count_r - 16'd1;
					end
				end
				ST_HOLD: begin
					// Held low at done, a new conversion begins at once
					if (!sync_r.convert_start_n) begin
						state_r <= ST_CONVERT;
						count_r <= 16'(acsp_pkg::CONVERT_START_N_CYCLES - 1);
					end else if (done_n_r) begin
						state_r <= ST_IDLE;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Done flag and serial shifter
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			done_n_r    <= 1'b1;
			shift_r     <= 16'd0;
			bits_left_r <= 5'd0;
			reading_r   <= 1'b0;
		end else if (convert_start_n_end) begin
			done_n_r    <= 1'b0;
			shift_r     <= sample_i;
			bits_left_r <= 5'(acsp_pkg::WORD_BITS);
			reading_r   <= 1'b0;
		end else if (adv && !sync_r.port_select_n && bits_left_r != 5'd0) begin
			// Unread data is overwritten by the next word, not queued
			shift_r     <= {shift_r[14:0], 1'b0};
			bits_left_r <= bits_left_r - 5'd1;
			reading_r   <= 1'b1;
			if (final_adv) begin
				done_n_r  <= 1'b1;
				reading_r <= 1'b0;
			end
		end else if (state_r == ST_CONVERT && !reading_r && !done_n_r &&
		             count_r == 16'(acsp_pkg::EARLY_CYCLES)) begin
			// A read under way keeps done low; only an untouched word is released
			done_n_r <= 1'b1;
		end
	end

	// Internal shift clock divider, master mode only
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			div_r  <= 3'd0;
			sclk_r <= 1'b0;
		end else if (self_mode && !done_n_r) begin
			div_r <= (div_r == 3'(acsp_pkg::SCLK_DIV - 1)) ? 3'd0 : div_r + 3'd1;
			if (div_r == 3'(acsp_pkg::SCLK_DIV - 1)) begin
				sclk_r <= ~sclk_r;
			end
		end else begin
			div_r  <= 3'd0;
			sclk_r <= 1'b0;
		end
	end

	// Pin drivers; tristate follows port select
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			conversion_done_n_o <= 1'b1;
			serial_result_out_o <= 1'b0;
			serial_result_oe_o  <= 1'b0;
			shift_clock_o       <= 1'b0;
			shift_clock_oe_o    <= 1'b0;
		end else begin
			conversion_done_n_o <= done_n_r;
			serial_result_out_o <= shift_r[15];
			serial_result_oe_o  <= ~sync_r.port_select_n;
			shift_clock_o       <= sclk_r;
			shift_clock_oe_o    <= self_mode & ~sync_r.port_select_n;
		end
	end

	// Sticky events, set wins over write-one clear
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			status_r <= 2'b00;
		end else begin
			status_r <= (status_r & ~(reg_hit(reg_write_i, reg_addr_i, acsp_pkg::ADDR_STATUS) ?
			            reg_wdata_i[1:0] : 2'b00)) | {final_adv, convert_start_n_end};
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			mask_r <= 2'b00;
		end else if (reg_hit(reg_write_i, reg_addr_i, acsp_pkg::ADDR_MASK)) begin
			mask_r <= reg_wdata_i[1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			irq_o       <= 1'b0;
			reg_rdata_o <= 16'd0;
		end else begin
			irq_o <= |(status_r & mask_r);
			if (reg_read_i) begin
				case (reg_addr_i)
					acsp_pkg::ADDR_STATUS: reg_rdata_o <= {14'd0, status_r};
					acsp_pkg::ADDR_MASK:   reg_rdata_o <= {14'd0, mask_r};
					acsp_pkg::ADDR_RESULT: reg_rdata_o <= result_r;
					default:               reg_rdata_o <= {11'd0, done_n_r, state_r, self_mode,
					                                       reading_r};
				endcase
			end else begin
				reg_rdata_o <= 16'd0;
			end
		end
	end

	done_low_a: assert property (@(posedge clk_i) disable iff (reset_i)
		convert_start_n_end |=> !done_n_r) else $error("done not low after conversion");
	hiz_a: assert property (@(posedge clk_i) disable iff (reset_i)
		sync_r.port_select_n |=> !serial_result_oe_o) else $error("output driven while deselected");
	start_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(state_r == ST_IDLE && !sync_r.convert_start_n) |=> state_r == ST_CONVERT)
		else $error("conversion not started");
	read_end_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(adv && bits_left_r == 5'd1 && !sync_r.port_select_n && !convert_start_n_end) |=> done_n_r)
		else $error("done not high after readout");
	shift_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(adv && bits_left_r != 5'd0 && !sync_r.port_select_n && !convert_start_n_end && !done_n_r)
		|=> shift_r == {$past(shift_r[14:0]), 1'b0}) else $error("bit not advanced");
	clk_oe_a: assert property (@(posedge clk_i) disable iff (reset_i)
		!self_mode |=> !shift_clock_oe_o) else $error("slave drove shift clock");

	// Checker helpers, counted apart from the datapath so they cannot share its faults
	logic [15:0] convert_start_n_len_r;
	logic [4:0]  shifted_r;
	logic [2:0]  sclk_run_r;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			convert_start_n_len_r <= 16'h0000;
		end else if (state_r == ST_CONVERT) begin
			convert_start_n_len_r <= convert_start_n_len_r + 16'h0001;
		end else begin
			convert_start_n_len_r <= 16'h0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			shifted_r <= 5'h00;
		end else if (convert_start_n_end) begin
			shifted_r <= 5'h00;
		end else if (adv && !sync_r.port_select_n && bits_left_r != 5'h00) begin
			shifted_r <= shifted_r + 5'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i || !sclk_r) begin
			sclk_run_r <= 3'h0;
		end else if (sclk_run_r != 3'h7) begin
			sclk_run_r <= sclk_run_r + 3'h1;
		end
	end

	sel_drive_a: assert property (@(posedge clk_i) disable iff (reset_i)
		!sync_r.port_select_n |=> serial_result_oe_o)
		else $error("output not driven while selected");
	desel_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(sync_r.port_select_n && !convert_start_n_end) |=> bits_left_r == $past(bits_left_r))
		else $error("bit shifted while deselected");
	master_oe_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(self_mode && !sync_r.port_select_n) |=> shift_clock_oe_o)
		else $error("master did not drive shift clock");
	sclk_high_a: assert property (@(posedge clk_i) disable iff (reset_i)
		sclk_r |-> sclk_run_r < 3'(acsp_pkg::SCLK_DIV))
		else $error("shift clock high too long");
	slave_sclk_a: assert property (@(posedge clk_i) disable iff (reset_i)
		!self_mode |=> !sclk_r)
		else $error("internal shift clock ran in slave mode");
	busy_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(state_r == ST_CONVERT && count_r != 16'h0000) |=> state_r == ST_CONVERT)
		else $error("conversion cut short");
	restart_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(state_r == ST_HOLD && !sync_r.convert_start_n) |=>
		(state_r == ST_CONVERT && count_r == 16'(acsp_pkg::CONVERT_START_N_CYCLES - 1)))
		else $error("held start did not repeat");
	convert_start_n_len_a: assert property (@(posedge clk_i) disable iff (reset_i)
		convert_start_n_end |-> convert_start_n_len_r == 16'(acsp_pkg::CONVERT_START_N_CYCLES - 1))
		else $error("conversion length wrong");
	done_rise_a: assert property (@(posedge clk_i) disable iff (reset_i)
		$rose(done_n_r) |-> (shifted_r == 5'(acsp_pkg::WORD_BITS)) ||
		(state_r == ST_CONVERT && count_r == 16'(acsp_pkg::EARLY_CYCLES - 1)))
		else $error("done rose at wrong time");
	done_event_a: assert property (@(posedge clk_i) disable iff (reset_i)
		convert_start_n_end |=> status_r[acsp_pkg::IRQ_DONE_BIT])
		else $error("done event not recorded");
	irq_level_a: assert property (@(posedge clk_i) disable iff (reset_i)
		1'b1 |=> irq_o == $past(|(status_r & mask_r)))
		else $error("interrupt level wrong");
	rdata_res_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(reg_read_i && reg_addr_i == acsp_pkg::ADDR_RESULT) |=> reg_rdata_o == $past(result_r))
		else $error("result read wrong");
	rdata_idle_a: assert property (@(posedge clk_i) disable iff (reset_i)
		!reg_read_i |=> reg_rdata_o == 16'h0000)
		else $error("read data outside read cycle");
endmodule // acsp_top

// ===== tb/acsp_host_model.sv
`timescale 1ns/1ps
module acsp_host_model (
	input  wire logic        clk_i,
	input  wire logic        go_i,
	input  wire logic        sdo_i,
	output logic             sclk_o,
	output logic [15:0]      word_o,
	output logic             busy_o
);
	// Shift clock stands low between frames
	initial begin
		sclk_o = 1'b0;
		word_o = 16'h0000;
		busy_o = 1'b0;
		forever begin
			@(posedge clk_i);
			if (go_i) begin
				busy_o <= 1'b1;
				for (int i = 0; i < 16; i++) begin
					// The bit standing now is latched as the clock rises
					word_o <= {word_o[14:0], sdo_i};
					sclk_o <= 1'b1;
					repeat (4) @(posedge clk_i);
					sclk_o <= 1'b0;
					repeat (4) @(posedge clk_i);
				end
				busy_o <= 1'b0;
			end
		end
	end
endmodule // acsp_host_model

// ===== tb/tb_adc_conversion_sequencing_port.sv
`timescale 1ns/1ps
module tb_adc_conversion_sequencing_port;
	logic        clk_i, reset_i, convert_start_n_n, sel_n, mode, go, wr_s, rd_s;
	logic        done_n, serial_result_out, sdo_oe, sck, sck_oe, irq, msclk, busy;
	logic [15:0] sample, wdata, rdata, rd_v, word;
	logic [1:0]  addr;
	int          bad_count = 0;
	int          checked = 0;
	acsp_top dut_u (.clk_i(clk_i), .reset_i(reset_i),
		.pins_i({convert_start_n_n, sel_n, mode, msclk}), .sample_i(sample), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_write_i(wr_s), .reg_read_i(rd_s), .reg_rdata_o(rdata),
		.conversion_done_n_o(done_n), .serial_result_out_o(serial_result_out), .serial_result_oe_o(sdo_oe),
		.shift_clock_o(sck), .shift_clock_oe_o(sck_oe), .irq_o(irq));
	acsp_host_model host_u (.clk_i(clk_i), .go_i(go), .sdo_i(serial_result_out), .sclk_o(msclk),
		.word_o(word), .busy_o(busy));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk_i);
		wr_s <= 1'b0;
		repeat (3) @(negedge clk_i);
	endtask
	task automatic rd(input logic [1:0] a);
		@(posedge clk_i);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_i);
		rd_s <= 1'b0;
		@(negedge clk_i);
		rd_v = rdata;
	endtask
	// Sampled at the falling edge so registered outputs have settled
	task automatic wait_done(input logic lvl, input int n);
		int k;
		k = 0;
		while (done_n !== lvl && k < n) begin
			@(negedge clk_i);
			k++;
		end
		chk({15'h0000, done_n}, {15'h0000, lvl});
	endtask
	task automatic convert(input logic [15:0] s);
		@(posedge clk_i);
		sample <= s;
		convert_start_n_n <= 1'b0;
		repeat (4) @(posedge clk_i);
		convert_start_n_n <= 1'b1;
		wait_done(1'b0, 420);
	endtask
	task automatic t_slave;
		wr(acsp_pkg::ADDR_MASK, 16'h0001);
		convert(16'ha5c3);
		chk({15'h0000, irq}, 16'h0001);
		rd(acsp_pkg::ADDR_RESULT);
		chk(rd_v, 16'ha5c3);
		chk({15'h0000, sdo_oe}, 16'h0001);
		@(posedge clk_i);
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		@(posedge clk_i);
		while (busy) @(posedge clk_i);
		chk(word, 16'ha5c3);
		wait_done(1'b1, 10);
		wr(acsp_pkg::ADDR_MASK, 16'h0000);
		chk({15'h0000, irq}, 16'h0000);
		wr(acsp_pkg::ADDR_STATUS, 16'h0003);
		wr(acsp_pkg::ADDR_MASK, 16'h0001);
		chk({15'h0000, irq}, 16'h0000);
	endtask
	task automatic t_desel;
		@(posedge clk_i);
		sel_n <= 1'b1;
		repeat (5) @(negedge clk_i);
		chk({14'h0000, sdo_oe, sck_oe}, 16'h0000);
		@(posedge clk_i);
		sel_n <= 1'b0;
	endtask
	task automatic t_master;
		logic [15:0] w;
		logic        sck_q;
		logic        sdo_q;
		int          n;
		int          k;
		@(posedge clk_i);
		mode <= 1'b1;
		convert(16'h3c5a);
		w = 16'h0000;
		n = 0;
		k = 0;
		sck_q = sck;
		sdo_q = serial_result_out;
		// Latch the bit that stood before each rising shift clock
		while (done_n !== 1'b1 && k < 200) begin
			@(negedge clk_i);
			k++;
			if (sck === 1'b1 && sck_q === 1'b0) begin
				n++;
				w = {w[14:0], sdo_q};
			end
			sck_q = sck;
			sdo_q = serial_result_out;
		end
		chk(16'(n), 16'h0010);
		chk(w, 16'h3c5a);
		chk({15'h0000, sck_oe}, 16'h0001);
		wait_done(1'b1, 10);
		@(posedge clk_i);
		mode <= 1'b0;
	endtask
	// Start held low and nothing read: the word is replaced each round
	task automatic t_held;
		@(posedge clk_i);
		sample <= 16'h1111;
		convert_start_n_n <= 1'b0;
		wait_done(1'b0, 420);
		@(posedge clk_i);
		sample <= 16'h2222;
		repeat (300) @(negedge clk_i);
		chk({15'h0000, done_n}, 16'h0000);
		wait_done(1'b1, 110);
		wait_done(1'b0, 6);
		rd(acsp_pkg::ADDR_RESULT);
		chk(rd_v, 16'h2222);
		@(posedge clk_i);
		convert_start_n_n <= 1'b1;
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	initial begin
		{reset_i, convert_start_n_n, sel_n, mode, go, wr_s, rd_s} = 7'h60;
		{sample, wdata, addr} = 34'h0_0000_0000;
		repeat (16) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (4) @(negedge clk_i);
		chk({12'h000, done_n, sdo_oe, sck_oe, irq}, 16'h000c);
		t_slave;
		t_desel;
		t_master;
		t_held;
		test_done;
	end
	initial begin
		#(25 * 12000);
		bad_count++;
		test_done;
	end
endmodule // tb_adc_conversion_sequencing_port
